// ==== verilog/rtc_i2c_pkg.sv ====
// Constants shared by the two-wire slave interface of the clock module
package rtc_i2c_pkg;
    localparam int          CLK_HZ          = 25_000_000;
    localparam int          TIMEOUT_MS      = 950;
    localparam int          TIMEOUT_CYC     = (CLK_HZ / 1000) * TIMEOUT_MS;
    localparam logic [6:0]  SLAVE_ADDR      = 7'h32;
    localparam logic [3:0]  REG_ADDR_RESET  = 4'h0;
    localparam logic [3:0]  REG_ADDR_LAST   = 4'hf;
    localparam logic [7:0]  READ_IDLE_BYTE  = 8'hff;
    localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
    localparam int          REG_ADDR_W      = 4;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_REGADR,
        ST_WDATA,
        ST_RDATA,
        ST_WAITP
    } slave_state_t;
endpackage

// ==== verilog/rtc_i2c_slave.sv ====
// Two-wire serial slave interface with address match, auto increment and bus timeout
`timescale 1ns/10ps
module rtc_i2c_slave
    import rtc_i2c_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_reset,
    input  wire logic                  i_scl,
    input  wire logic                  i_sda,
    output logic                       o_scl,
    output logic                       o_scl_oe_n,
    output logic                       o_sda,
    output logic                       o_sda_oe_n,
    output logic [REG_ADDR_W-1:0]      o_reg_addr,
    output logic [7:0]                 o_wr_data,
    output logic                       o_wr_stb,
    input  wire logic [7:0]            i_rd_data,
    output logic                       o_rd_stb,
    output logic                       o_freeze,
    output logic                       o_timeout
);

    // Two-stage synchronisers; stage one is read by stage two only
    logic [1:0]         scl_sync_ff;
    logic [1:0]         sda_sync_ff;
    logic               scl_d_ff;
    logic               sda_d_ff;
    slave_state_t       state_ff;
    slave_state_t       nxt_state;
    logic [3:0]         bit_cnt_ff;
    logic [7:0]         shift_ff;
    logic               ack_phase_ff;
    logic               ack_bit_ff;
    logic               sda_low_ff;
    logic [REG_ADDR_W-1:0] reg_addr_ff;
    logic [7:0]         wr_data_ff;
    logic               wr_stb_ff;
    logic               rd_stb_ff;
    logic               freeze_ff;
    logic               timeout_ff;
    logic [31:0]        tmo_cnt_ff;
    logic               in_frame_ff;

    wire scl = scl_sync_ff[1];
    wire sda = sda_sync_ff[1];
    wire scl_rise  = scl & ~scl_d_ff;
    wire scl_fall  = ~scl & scl_d_ff;
    wire start_det = scl & scl_d_ff & sda_d_ff & ~sda;
    wire stop_det  = scl & scl_d_ff & ~sda_d_ff & sda;
    wire byte_done = scl_fall & ~ack_phase_ff & (bit_cnt_ff == BITS_PER_BYTE - 4'h1);
    wire ack_done  = scl_fall & ack_phase_ff;
    wire [7:0] rx_byte = {shift_ff[6:0], sda};
    wire       addr_hit = (shift_ff[7:1] == SLAVE_ADDR);
    wire       tmo_hit  = in_frame_ff & (tmo_cnt_ff >= TIMEOUT_CYCLES - 1);
    wire [7:0] tx_byte  = timeout_ff ? READ_IDLE_BYTE : i_rd_data;
    // Master's acknowledge is taken while the clock is high, not at its fall
    wire       ack_sample = scl_rise & ack_phase_ff;
    // Pointer moves once the read byte is out, so the next load sees it
    wire       rd_advance = byte_done & (state_ff == ST_RDATA) & ~timeout_ff;

    function automatic logic [REG_ADDR_W-1:0] addr_inc(input logic [REG_ADDR_W-1:0] a);
        // Explicit compare with REG_ADDR_LAST, reloading REG_ADDR_RESET, gives the Fh to 0h wrap
        addr_inc = (a == REG_ADDR_LAST) ? REG_ADDR_RESET : a + 1'b1;
    endfunction

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            scl_d_ff    <= 1'b1;
            sda_d_ff    <= 1'b1;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], i_scl};
            sda_sync_ff <= {sda_sync_ff[0], i_sda};
            scl_d_ff    <= scl;
            sda_d_ff    <= sda;
        end
    end

    // Frame timer on core clock so a stalled bus clock still times out
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            in_frame_ff <= 1'b0;
            tmo_cnt_ff  <= 32'h0;
        end else if (start_det) begin
            in_frame_ff <= 1'b1;
            tmo_cnt_ff  <= 32'h0;
        end else if (stop_det || tmo_hit) begin
            in_frame_ff <= 1'b0;
            tmo_cnt_ff  <= 32'h0;
        end else if (in_frame_ff) begin
            tmo_cnt_ff  <= tmo_cnt_ff + 32'h1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            timeout_ff <= 1'b0;
        end else if (start_det) begin
            timeout_ff <= 1'b0;
        end else if (tmo_hit) begin
            timeout_ff <= 1'b1;
        end
    end

    // Next state decided at START, STOP or timeout, at the ACK falling edge, or at byte end on an address miss
    always_comb begin
        nxt_state = state_ff;
        if (start_det) begin
            nxt_state = ST_ADDR;
        end else if (stop_det || tmo_hit) begin
            nxt_state = ST_IDLE;
        end else if (byte_done && state_ff == ST_ADDR && !addr_hit) begin
            nxt_state = ST_IDLE;
        end else if (ack_done) begin
            unique case (state_ff)
                ST_ADDR:   nxt_state = shift_ff[0] ? ST_RDATA : ST_REGADR;
                ST_REGADR: nxt_state = ST_WDATA;
                ST_WDATA:  nxt_state = ST_WDATA;
                ST_RDATA:  nxt_state = ack_bit_ff ? ST_WAITP : ST_RDATA;
                ST_WAITP:  nxt_state = ST_WAITP;
                ST_IDLE:   nxt_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset || start_det) begin
            ack_bit_ff <= 1'b1;
        end else if (ack_sample) begin
            ack_bit_ff <= sda;
        end
    end

    // Bit counter and shifter; bits sampled on clock rise
    // The clock fall that closes a START wraps the counter to zero
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            bit_cnt_ff   <= 4'h0;
            ack_phase_ff <= 1'b0;
            shift_ff     <= 8'h0;
        end else if (start_det) begin
            bit_cnt_ff   <= 4'hf;
            ack_phase_ff <= 1'b0;
            shift_ff     <= 8'h0;
        end else if (scl_rise && !ack_phase_ff && state_ff != ST_RDATA) begin
            shift_ff     <= rx_byte;
        end else if (byte_done) begin
            bit_cnt_ff   <= 4'h0;
            ack_phase_ff <= 1'b1;
        end else if (ack_done) begin
            ack_phase_ff <= 1'b0;
            if (nxt_state == ST_RDATA) begin
                shift_ff <= tx_byte;
            end
        end else if (scl_fall && !ack_phase_ff) begin
            bit_cnt_ff   <= bit_cnt_ff + 4'h1;
            if (state_ff == ST_RDATA) begin
                shift_ff <= {shift_ff[6:0], 1'b1};
            end
        end
    end

    // Register address pointer survives between transactions
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            reg_addr_ff <= REG_ADDR_RESET;
        end else if (rd_advance) begin
            reg_addr_ff <= addr_inc(reg_addr_ff);
        end else if (ack_done && !timeout_ff) begin
            unique case (state_ff)
                ST_REGADR: reg_addr_ff <= shift_ff[REG_ADDR_W-1:0];
                ST_WDATA:  reg_addr_ff <= addr_inc(reg_addr_ff);
                default:   reg_addr_ff <= reg_addr_ff;
            endcase
        end
    end

    // Write strobe only for acknowledged bytes outside a timeout
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            wr_stb_ff  <= 1'b0;
            rd_stb_ff  <= 1'b0;
            wr_data_ff <= 8'h0;
        end else begin
            wr_stb_ff  <= ack_done && state_ff == ST_WDATA && !timeout_ff;
            rd_stb_ff  <= ack_done && nxt_state == ST_RDATA;
            if (ack_done && state_ff == ST_WDATA) begin
                wr_data_ff <= shift_ff;
            end
        end
    end

    // Data line drive: ACK, or read bit; changes after clock falls, except release at once on START, STOP or timeout
    always_ff @(posedge i_core_clk) begin
        if (i_reset || start_det || stop_det || tmo_hit) begin
            sda_low_ff <= 1'b0;
        end else if (byte_done) begin
            sda_low_ff <= (state_ff == ST_ADDR && addr_hit) ||
                          state_ff == ST_REGADR || state_ff == ST_WDATA;
        end else if (ack_done) begin
            sda_low_ff <= (nxt_state == ST_RDATA) & ~tx_byte[7];
        end else if (scl_fall && state_ff == ST_RDATA && !ack_phase_ff) begin
            sda_low_ff <= (bit_cnt_ff == BITS_PER_BYTE - 4'h1) ? 1'b0 : ~shift_ff[6];
        end
    end

    // Freeze shown to timekeeping while a frame is open
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            freeze_ff <= 1'b0;
        end else begin
            freeze_ff <= in_frame_ff & ~stop_det & ~tmo_hit;
        end
    end

    assign o_scl      = 1'b0;
    assign o_scl_oe_n = 1'b1;
    assign o_sda      = 1'b0;
    assign o_sda_oe_n = ~sda_low_ff;
    assign o_reg_addr = reg_addr_ff;
    assign o_wr_data  = wr_data_ff;
    assign o_wr_stb   = wr_stb_ff;
    assign o_rd_stb   = rd_stb_ff;
    assign o_freeze   = freeze_ff;
    assign o_timeout  = timeout_ff;

endmodule // rtc_i2c_slave

// ==== sim/rtc_i2c_slave_props.sv ====
// Port-level checks on the two-wire slave interface
`timescale 1ns/10ps
module rtc_i2c_slave_props
    import rtc_i2c_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = 2000
) (
    input wire logic                  i_core_clk,
    input wire logic                  i_reset,
    input wire logic                  i_scl,
    input wire logic                  i_sda,
    input wire logic                  o_scl,
    input wire logic                  o_scl_oe_n,
    input wire logic                  o_sda,
    input wire logic                  o_sda_oe_n,
    input wire logic [REG_ADDR_W-1:0] o_reg_addr,
    input wire logic [7:0]            o_wr_data,
    input wire logic                  o_wr_stb,
    input wire logic [7:0]            i_rd_data,
    input wire logic                  o_rd_stb,
    input wire logic                  o_freeze,
    input wire logic                  o_timeout
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    // Pin edges seen three core edges late, so six cycles of slack
    property p_start_open; i_scl && $fell(i_sda) |-> ##[1:6] o_freeze; endproperty
    a_start_open: assert property (p_start_open) else $error("freeze not raised");
    property p_start_clr; i_scl && $fell(i_sda) |-> ##[1:6] !o_timeout; endproperty
    a_start_clr: assert property (p_start_clr) else $error("timeout not cleared");
    property p_stop_close; i_scl && $rose(i_sda) |-> ##[1:6] !o_freeze; endproperty
    a_stop_close: assert property (p_stop_close) else $error("frame not closed");
    property p_scl_idle; o_scl_oe_n && !o_scl; endproperty
    a_scl_idle: assert property (p_scl_idle) else $error("clock line driven");
    property p_sda_low; !o_sda_oe_n |-> !o_sda; endproperty
    a_sda_low: assert property (p_sda_low) else $error("data driven high");
    property p_quiet; !o_freeze |-> o_sda_oe_n; endproperty
    a_quiet: assert property (p_quiet) else $error("data driven outside frame");
    property p_wr_once; o_wr_stb |=> !o_wr_stb; endproperty
    a_wr_once: assert property (p_wr_once) else $error("write strobe too long");
    property p_wr_step; o_wr_stb |-> o_reg_addr == $past(o_reg_addr) + 4'h1; endproperty
    a_wr_step: assert property (p_wr_step) else $error("pointer not advanced");
    property p_to_mute; o_timeout |-> !o_wr_stb && o_sda_oe_n; endproperty
    a_to_mute: assert property (p_to_mute) else $error("active after timeout");
    property p_to_cause; $rose(o_timeout) |-> $past(o_freeze) && !o_freeze; endproperty
    a_to_cause: assert property (p_to_cause) else $error("timeout without frame");
    c_wr: cover property (o_wr_stb);
    c_rd: cover property (o_rd_stb);
    c_to: cover property ($rose(o_timeout));
endmodule // rtc_i2c_slave_props

// ==== sim/i2c_master_model.sv ====
// Behavioural bus master pulling the two lines low or releasing them
`timescale 1ns/10ps
module i2c_master_model (
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic start();
        #40 o_sda = 1'b1;
        #160 o_scl = 1'b1;
        #80 o_sda = 1'b0;
        #80 o_scl = 1'b0;
    endtask
    task automatic stop();
        #40 o_sda = 1'b0;
        #160 o_scl = 1'b1;
        #80 o_sda = 1'b1;
        #1440;
    endtask
    // Top n bits of b, MSB first; long low phase leaves room for the slave's late turn
    task automatic bits(input logic [8:0] b, input int n, output logic [8:0] r);
        r = 9'h1ff;
        for (int i = 8; i > 8 - n; i--) begin
            #40 o_sda = b[i];
            #160 o_scl = 1'b1;
            #80 r[i] = i_sda;
            #40 o_scl = 1'b0;
        end
        o_sda = 1'b1;
    endtask
endmodule // i2c_master_model

// ==== sim/test_rtc_i2c_slave_interface.sv ====
// Self-checking bench for the two-wire slave interface
`timescale 1ns/10ps
module test_rtc_i2c_slave_interface;
    import rtc_i2c_pkg::*;
    localparam int TO_CYC = 2000;
    logic                  i_core_clk = 1'b0;
    logic                  i_reset    = 1'b1;
    logic                  o_scl, o_scl_oe_n, o_sda, o_sda_oe_n, o_wr_stb, o_rd_stb;
    logic                  o_freeze, o_timeout;
    logic [REG_ADDR_W-1:0] o_reg_addr;
    logic [7:0]            o_wr_data, wr_last;
    logic [8:0]            rx;
    int                    n_mismatch = 0, checks = 0, n_wr = 0, n0 = 0, n_rd = 0, n1 = 0;
    wire                   m_scl, m_sda;
    wire                   scl = m_scl & (o_scl_oe_n | o_scl);
    wire                   sda = m_sda & (o_sda_oe_n | o_sda);
    wire  [7:0]            rd_data = {4'ha, o_reg_addr};
    rtc_i2c_slave #(.TIMEOUT_CYCLES(TO_CYC)) i_dut (.i_core_clk, .i_reset, .i_scl(scl),
        .i_sda(sda), .o_scl, .o_scl_oe_n, .o_sda, .o_sda_oe_n, .o_reg_addr, .o_wr_data,
        .o_wr_stb, .i_rd_data(rd_data), .o_rd_stb, .o_freeze, .o_timeout);
    i2c_master_model i_m (.i_sda(sda), .o_scl(m_scl), .o_sda(m_sda));
    always #20 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        if (o_wr_stb === 1'b1) begin
            n_wr++;
            wr_last <= o_wr_data;
        end
        if (o_rd_stb === 1'b1) begin
            n_rd++;
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    task automatic tx(input logic [7:0] b, input logic ack);
        i_m.bits({b, 1'b1}, 9, rx);
        chk("ack", {7'h0, ack}, {7'h0, rx[0]});
    endtask
    task automatic rd(input logic [7:0] exp, input logic last);
        i_m.bits({8'hff, last}, 9, rx);
        chk("read", exp, rx[8:1]);
    endtask
    task automatic t_write_wrap();
        n0 = n_wr;
        i_m.start();
        tx(8'h64, 1'b0);
        tx(8'h0f, 1'b0);
        chk("freeze", 8'h1, {7'h0, o_freeze});
        tx(8'h5a, 1'b0);
        wt(8);
        chk("reg ptr", 8'h0, {4'h0, o_reg_addr});
        tx(8'hc3, 1'b0);
        i_m.stop();
        chk("wr data", 8'hc3, wr_last);
        chk("wr count", 8'h2, 8'(n_wr - n0));
        chk("freeze", 8'h0, {7'h0, o_freeze});
    endtask
    task automatic t_read_directed();
        n1 = n_rd;
        i_m.start();
        tx(8'h64, 1'b0);
        tx(8'h0f, 1'b0);
        i_m.start();
        tx(8'h65, 1'b0);
        rd(8'haf, 1'b0);
        rd(8'ha0, 1'b1);
        wt(8);
        chk("released", 8'h1, {7'h0, sda});
        chk("rd count", 8'h2, 8'(n_rd - n1));
        i_m.stop();
    endtask
    task automatic t_misc();
        i_m.start();
        tx(8'h65, 1'b0);
        rd(8'ha1, 1'b1);
        i_m.stop();
        n0 = n_wr;
        i_m.start();
        tx(8'h66, 1'b1);
        tx(8'h00, 1'b1);
        i_m.stop();
        i_m.start();
        tx(8'h64, 1'b0);
        tx(8'h03, 1'b0);
        i_m.bits(9'h140, 4, rx);
        i_m.stop();
        chk("wr count", 8'h0, 8'(n_wr - n0));
        chk("freeze", 8'h0, {7'h0, o_freeze});
    endtask
    task automatic t_timeout();
        i_m.start();
        tx(8'h65, 1'b0);
        wt(TO_CYC + 100);
        chk("timeout", 8'h1, {7'h0, o_timeout});
        rd(8'hff, 1'b0);
        i_m.stop();
        i_m.start();
        wt(8);
        chk("timeout", 8'h0, {7'h0, o_timeout});
        i_m.stop();
    endtask
    task automatic close_out();
        if (n_mismatch == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        wt(6);
        i_reset = 1'b0;
        wt(4);
        t_write_wrap();
        t_read_directed();
        t_misc();
        t_timeout();
        close_out();
    end
    initial begin
        #2_000_000;
        n_mismatch++;
        close_out();
    end
endmodule // test_rtc_i2c_slave_interface
bind rtc_i2c_slave rtc_i2c_slave_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_props (
    .i_core_clk, .i_reset, .i_scl, .i_sda, .o_scl, .o_scl_oe_n, .o_sda, .o_sda_oe_n,
    .o_reg_addr, .o_wr_data, .o_wr_stb, .i_rd_data, .o_rd_stb, .o_freeze, .o_timeout);
